// ===== psc_regs.vh
`ifndef PSC_REGS_VH
`define PSC_REGS_VH

// strap bus width, positions 20..0
`define PSC_STRAP_W      21
`define PSC_SYNC_STAGES  3

// wishbone geometry, byte address = 4 * index
`define PSC_ADR_W        10
`define PSC_IDX_W        8

// register indices
`define PSC_IDX_UMA      8'h28
`define PSC_IDX_DBG      8'h31
`define PSC_IDX_CFG      8'h3f
`define PSC_IDX_MCLK     8'h30
`define PSC_IDX_DEVID    8'h24
`define PSC_IDX_STRAP0   8'h20
`define PSC_IDX_STRAP1   8'h21
`define PSC_IDX_STRAP2   8'h22
`define PSC_IDX_STAT     8'h23

// field positions
`define PSC_UMA_BIT      0
`define PSC_DBG_BIT      0
`define PSC_MCLK_BIT     0
`define PSC_DIDSEL_BIT   3
`define PSC_CPN_BIT      2
`define PSC_STAT_DONE    0

// strap positions
`define PSC_MD_DIDSEL    6
`define PSC_MD_UMA       7
`define PSC_MD_MCLK      12
`define PSC_MD_DBG       20
`define PSC_MD_USED      21'h10_10c0

// reset values
`define PSC_RST_UMA      1'b0
`define PSC_RST_DBG      1'b0
`define PSC_RST_MCLK     1'b0
`define PSC_RST_DIDSEL   1'b0
`define PSC_RST_CPN      1'b1
`define PSC_RST_STRAP    21'h00_0000

// device ids, values arbitrary
`define PSC_BASE_ID      16'h1a50
`define PSC_ALT_ID       16'h1a51

`endif

// ===== psc_pin_sync.v
`timescale 1ns/1ps
`default_nettype none
`include "psc_regs.vh"

// three-stage pin synchroniser, value moves once stages 2 and 3 agree
module psc_pin_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input  wire         clk_i,
  input  wire [W-1:0] pin_i,
  output wire [W-1:0] filt_o
);

  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      reg s1 = INIT[g];
      reg s2 = INIT[g];
      reg s3 = INIT[g];
      reg f  = INIT[g];
      // free running so straps are sampled while reset is held
      always @(posedge clk_i) begin
        s1 <= pin_i[g];
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3) begin
          f <= s3;
        end
      end
      assign filt_o[g] = f;
    end
  endgenerate

endmodule // psc_pin_sync
`default_nettype wire

// ===== psc_strap_capture.v
// The Wishbone slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "psc_regs.vh"

module psc_strap_capture (
  input  wire                    clk_i,
  input  wire                    rst_i,
  // strap, companion detect and rom cycle request pins
  input  wire [`PSC_STRAP_W-1:0] memory_data_strap_pins_i,
  input  wire                    companion_detect_pin_i,
  input  wire                    rom_cycle_req_i,
  // wishbone slave
  input  wire                    wb_cyc_i,
  input  wire                    wb_stb_i,
  input  wire                    wb_we_i,
  input  wire [`PSC_ADR_W-1:0]   wb_adr_i,
  input  wire [3:0]              wb_sel_i,
  input  wire [31:0]             wb_dat_i,
  output reg  [31:0]             wb_dat_o,
  output reg                     wb_ack_o,
  // configuration outputs
  output reg  [15:0]             device_id_o,
  output reg                     device_id_select_o,
  output reg                     unified_mem_request_enable_o,
  output reg                     mem_bus_req_o,
  output reg                     external_memclk_select_o,
  output reg                     debug_mode_enable_o,
  output reg                     companion_present_n_o,
  output reg                     straps_captured_o
);

  localparam [2:0] ST_HOLD    = 3'b001;
  localparam [2:0] ST_CAPTURE = 3'b010;
  localparam [2:0] ST_RUN     = 3'b100;

  reg  [2:0]              state;
  reg  [2:0]              next_state;
  reg  [`PSC_STRAP_W-1:0] strap_raw;
  reg                     uma_en;
  reg                     dbg_en;
  reg                     mclk_ext;
  reg                     did_sel;
  reg                     cpn;
  reg  [31:0]             next_dat;

  wire [`PSC_STRAP_W-1:0] strap_filt;
  wire                    detect_filt;
  wire [`PSC_IDX_W-1:0]   idx;
  wire                    req;
  wire                    wr;
  wire                    capture;
  wire [15:0]             next_id;
  wire                    wr_uma;
  wire                    wr_dbg;
  wire                    wr_mclk;
  wire                    wr_cfg;

  // pins synchronised; pulls resolved on the wire outside
  psc_pin_sync #(
    .W    (`PSC_STRAP_W),
    .INIT (`PSC_RST_STRAP)
  ) u_strap_sync (
    .clk_i  (clk_i),
    .pin_i  (memory_data_strap_pins_i),
    .filt_o (strap_filt)
  );

  psc_pin_sync #(
    .W    (1),
    .INIT (`PSC_RST_CPN)
  ) u_detect_sync (
    .clk_i  (clk_i),
    .pin_i  (companion_detect_pin_i),
    .filt_o (detect_filt)
  );

  assign idx     = wb_adr_i[`PSC_ADR_W-1:2];
  assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr      = req & wb_we_i & wb_sel_i[0] & state[2];
  assign capture = state[1];

  // write strobes, one per writable register
  assign wr_uma  = wr & (idx == `PSC_IDX_UMA);
  assign wr_dbg  = wr & (idx == `PSC_IDX_DBG);
  assign wr_mclk = wr & (idx == `PSC_IDX_MCLK);
  assign wr_cfg  = wr & (idx == `PSC_IDX_CFG);

  // id choice
  assign next_id = (did_sel & ~cpn) ? `PSC_ALT_ID
                                    : `PSC_BASE_ID;

  // capture sequencer
  always @* begin
    case (state)
      ST_HOLD:    next_state = ST_CAPTURE;
      ST_CAPTURE: next_state = ST_RUN;
      ST_RUN:     next_state = ST_RUN;
      default:    next_state = ST_HOLD;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // configuration bits: strap load, then software override
  // reserved positions kept for readback only
  always @(posedge clk_i) begin
    if (rst_i) begin
      strap_raw <= `PSC_RST_STRAP;
    end else if (capture) begin
      strap_raw <= strap_filt;
    end
  end

  // capture wins over a write in the same cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      uma_en <= `PSC_RST_UMA;
    end else if (capture) begin
      uma_en <= strap_filt[`PSC_MD_UMA];
    end else if (wr_uma) begin
      uma_en <= wb_dat_i[`PSC_UMA_BIT];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      dbg_en <= `PSC_RST_DBG;
    end else if (capture) begin
      dbg_en <= strap_filt[`PSC_MD_DBG];
    end else if (wr_dbg) begin
      dbg_en <= wb_dat_i[`PSC_DBG_BIT];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      mclk_ext <= `PSC_RST_MCLK;
    end else if (capture) begin
      mclk_ext <= strap_filt[`PSC_MD_MCLK];
    end else if (wr_mclk) begin
      mclk_ext <= wb_dat_i[`PSC_MCLK_BIT];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      did_sel <= `PSC_RST_DIDSEL;
    end else if (capture) begin
      did_sel <= strap_filt[`PSC_MD_DIDSEL];
    end else if (wr_cfg) begin
      did_sel <= wb_dat_i[`PSC_DIDSEL_BIT];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      cpn <= `PSC_RST_CPN;
    end else if (capture) begin
      cpn <= detect_filt;
    end else if (wr_cfg) begin
      cpn <= wb_dat_i[`PSC_CPN_BIT];
    end
  end

  // read data
  always @* begin
    next_dat = 32'h0000_0000;
    case (idx)
      `PSC_IDX_UMA: begin
        next_dat[`PSC_UMA_BIT] = uma_en;
      end
      `PSC_IDX_DBG: begin
        next_dat[`PSC_DBG_BIT] = dbg_en;
      end
      `PSC_IDX_MCLK: begin
        next_dat[`PSC_MCLK_BIT] = mclk_ext;
      end
      `PSC_IDX_CFG: begin
        next_dat[`PSC_DIDSEL_BIT] = did_sel;
        next_dat[`PSC_CPN_BIT]    = cpn;
      end
      `PSC_IDX_DEVID: begin
        next_dat[15:0] = next_id;
      end
      `PSC_IDX_STRAP0: begin
        next_dat[7:0] = strap_raw[7:0];
      end
      `PSC_IDX_STRAP1: begin
        next_dat[7:0] = strap_raw[15:8];
      end
      `PSC_IDX_STRAP2: begin
        next_dat[4:0] = strap_raw[20:16];
      end
      `PSC_IDX_STAT: begin
        next_dat[`PSC_STAT_DONE] = state[2];
      end
      default: begin
        next_dat = 32'h0000_0000;
      end
    endcase
  end

  // wishbone answer, one wait state
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (req & ~wb_we_i) begin
        wb_dat_o <= next_dat;
      end
    end
  end

  // registered configuration outputs
  // id follows select and companion state
  always @(posedge clk_i) begin
    if (rst_i) begin
      device_id_o <= `PSC_BASE_ID;
    end else begin
      device_id_o <= next_id;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      device_id_select_o <= `PSC_RST_DIDSEL;
    end else begin
      device_id_select_o <= did_sel;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      unified_mem_request_enable_o <= `PSC_RST_UMA;
    end else begin
      unified_mem_request_enable_o <= uma_en;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      mem_bus_req_o <= 1'b0;
    end else begin
      mem_bus_req_o <= uma_en & rom_cycle_req_i;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      external_memclk_select_o <= `PSC_RST_MCLK;
    end else begin
      external_memclk_select_o <= mclk_ext;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      debug_mode_enable_o <= `PSC_RST_DBG;
    end else begin
      debug_mode_enable_o <= dbg_en;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      companion_present_n_o <= `PSC_RST_CPN;
    end else begin
      companion_present_n_o <= cpn;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      straps_captured_o <= 1'b0;
    end else begin
      straps_captured_o <= state[2];
    end
  end

endmodule // psc_strap_capture
`default_nettype wire

// ===== psc_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module psc_far_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        present_i,
  input  wire logic [20:0] drv_en_i,
  output logic      [20:0] strap_o,
  output logic             detect_o
);
  logic [2:0] hold = 3'h0;
  // companion keeps the pin low a few cycles past release
  always @(posedge clk_i) begin
    if (rst_i) hold <= 3'h5;
    else if (hold != 3'h0) hold <= hold - 3'h1;
  end
  assign strap_o = drv_en_i & 21'h10_10e1;
  assign detect_o = ~(present_i & (rst_i | (hold != 3'h0)));
endmodule // psc_far_model
`default_nettype wire

// ===== psc_strap_capture_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "psc_regs.vh"
module psc_strap_capture_sva (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        rom_cycle_req_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [15:0] device_id_o,
  input wire logic        device_id_select_o,
  input wire logic        unified_mem_request_enable_o,
  input wire logic        mem_bus_req_o,
  input wire logic        debug_mode_enable_o,
  input wire logic        companion_present_n_o,
  input wire logic        straps_captured_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  ack_on_req_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  ack_has_req_a: assert property (
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  id_choice_a: assert property (
    $stable(device_id_select_o) && $stable(companion_present_n_o) |->
    device_id_o == ((device_id_select_o && !companion_present_n_o) ?
    `PSC_ALT_ID : `PSC_BASE_ID)) else $error("bad id");
  bus_req_gate_a: assert property (
    $stable(unified_mem_request_enable_o) |-> mem_bus_req_o ==
    ($past(rom_cycle_req_i) && unified_mem_request_enable_o))
    else $error("bad bus req");
  reset_state_a: assert property (disable iff (1'b0)
    rst_i |=> !straps_captured_o && !debug_mode_enable_o &&
    companion_present_n_o && device_id_o == `PSC_BASE_ID)
    else $error("bad reset state");
  capture_timing_a: assert property (
    $fell(rst_i) |-> !straps_captured_o ##1 !straps_captured_o
    ##1 !straps_captured_o ##1 straps_captured_o)
    else $error("capture late");
  capture_holds_a: assert property (
    straps_captured_o |=> straps_captured_o) else $error("capture lost");
  cover property ($rose(straps_captured_o));
  cover property (mem_bus_req_o);
  cover property (device_id_o == `PSC_ALT_ID);
endmodule // psc_strap_capture_sva
bind psc_strap_capture psc_strap_capture_sva chk_u (.clk_i, .rst_i,
  .rom_cycle_req_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .device_id_o,
  .device_id_select_o, .unified_mem_request_enable_o, .mem_bus_req_o,
  .debug_mode_enable_o, .companion_present_n_o, .straps_captured_o);
`default_nettype wire

// ===== psc_strap_capture_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "psc_regs.vh"
module psc_strap_capture_tb;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0;
  logic rom = 1'b0, pres = 1'b1;
  logic [7:0] idx = 8'h00;
  logic [31:0] wd = 32'h0000_0000, q;
  logic [20:0] en = 21'h1f_ffff;
  wire [31:0] rd;
  wire [15:0] id;
  wire [20:0] md;
  wire ack, sel, uma, mreq, mclk, dbg, cpn, done, det;
  wire [31:0] cfg = {26'h000_0000, sel, uma, mclk, dbg, cpn, done};
  int err_total = 0, cmp_count = 0;
  always #25 clk_i = ~clk_i;
  psc_far_model far_u (.clk_i, .rst_i, .present_i(pres), .drv_en_i(en),
    .strap_o(md), .detect_o(det));
  psc_strap_capture dut_u (.clk_i, .rst_i, .memory_data_strap_pins_i(md),
    .companion_detect_pin_i(det), .rom_cycle_req_i(rom), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i({idx, 2'b00}),
    .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
    .device_id_o(id), .device_id_select_o(sel),
    .unified_mem_request_enable_o(uma), .mem_bus_req_o(mreq),
    .external_memclk_select_o(mclk), .debug_mode_enable_o(dbg),
    .companion_present_n_o(cpn), .straps_captured_o(done));
  task automatic complete_run;
    $display("compares %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic tick;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    idx <= a;
    wd <= {24'h00_0000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      err_total++;
      complete_run;
    end
    q = rd;
    cyc <= 1'b0;
    tick;
  endtask
  task automatic do_reset(input logic p, input logic [20:0] e);
    @(posedge clk_i);
    rst_i <= 1'b1;
    pres <= p;
    en <= e;
    repeat (5) @(posedge clk_i);
    #1 chk("held", cfg, 32'h0000_0002);
    @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    en <= 21'h00_0000;
    tick;
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    do_reset(1'b1, 21'h1f_ffff);
    chk("cfg", cfg, 32'h0000_003d);
    chk("id", {16'h0000, id}, {16'h0000, `PSC_ALT_ID});
    bus(1'b0, 8'h3f, 8'h00);
    chk("idx3f", q, 32'h0000_0008);
    bus(1'b0, 8'h20, 8'h00);
    chk("raw", q, 32'h0000_00e1);
    bus(1'b0, 8'h22, 8'h00);
    chk("raw2", q, 32'h0000_0010);
    bus(1'b0, 8'h24, 8'h00);
    chk("idreg", q, {16'h0000, `PSC_ALT_ID});
    bus(1'b0, 8'h23, 8'h00);
    chk("done", q, 32'h0000_0001);
    bus(1'b0, 8'h10, 8'h00);
    chk("unmapped", q, 32'h0000_0000);
    bus(1'b1, 8'h31, 8'h00);
    bus(1'b1, 8'h3f, 8'h0c);
    chk("sw", cfg, 32'h0000_003b);
    chk("id", {16'h0000, id}, {16'h0000, `PSC_BASE_ID});
    @(posedge clk_i) rom <= 1'b1;
    tick;
    chk("req", {31'h0000_0000, mreq}, 32'h0000_0001);
    bus(1'b1, 8'h28, 8'h00);
    chk("req", {31'h0000_0000, mreq}, 32'h0000_0000);
    do_reset(1'b0, 21'h00_0000);
    chk("cfg", cfg, 32'h0000_0003);
    bus(1'b1, 8'h3f, 8'h08);
    bus(1'b1, 8'h28, 8'h01);
    bus(1'b1, 8'h30, 8'h01);
    chk("sw", cfg, 32'h0000_0039);
    chk("id", {16'h0000, id}, {16'h0000, `PSC_ALT_ID});
    complete_run;
  end
endmodule // psc_strap_capture_tb
`default_nettype wire
